// File: hw/aws_shift_register.sv
// Asynchronous reversible word shift register with AHB-Lite slave
`include "aws_defs.svh"

module aws_shift_register #(
    parameter int DEPTH = 64,
    parameter int AREA_WORDS = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Interrupt
    output logic irq
);
    import aws_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [15:0] mem [DEPTH];

    function automatic logic isBcd(logic [15:0] w);
        return (w[3:0] <= 4'h9) && (w[7:4] <= 4'h9) &&
               (w[11:8] <= 4'h9) && (w[15:12] <= 4'h9);
    endfunction

    function automatic logic [15:0] bcdToBin(logic [15:0] w);
        logic [15:0] d3, d2, d1, d0;
        d3 = {12'h000, w[15:12]};
        d2 = {12'h000, w[11:8]};
        d1 = {12'h000, w[7:4]};
        d0 = {12'h000, w[3:0]};
        return 16'((d3 * 16'd1000) + (d2 * 16'd100) + (d1 * 16'd10) + d0);
    endfunction

    function automatic logic [15:0] areaOf(logic [15:0] a);
        return a / 16'(AREA_WORDS);
    endfunction

    // Operands past memory, non-BCD pointers and pointers past the end fail
    function automatic aws_resolve_type resolve(aws_operand_type op);
        aws_resolve_type r;
        logic [15:0] ptr;
        r.err = 1'b0;
        r.addr = op.addr;
        ptr = `AWS_RST_WORD;
        if (op.addr >= 16'(DEPTH)) begin
            r.err = 1'b1;
        end else if (op.indirect) begin
            ptr = mem[op.addr[AW-1:0]];
            if (!isBcd(ptr)) begin
                r.err = 1'b1;
            end else begin
                r.addr = bcdToBin(ptr);
                if (r.addr >= 16'(DEPTH)) begin
                    r.err = 1'b1;
                end
            end
        end
        return r;
    endfunction

    // Bus phase tracking
    logic dValid;
    logic dWrite;
    logic [11:0] dAddr;

    // Software visible registers
    aws_cword_type cword;
    aws_operand_type startOp;
    aws_operand_type endOp;
    logic errorFlag;
    logic [`AWS_EV_W-1:0] irqStat;
    logic [`AWS_EV_W-1:0] irqMask;

    // Sequencer state
    aws_state_type state;
    aws_state_type next_state;
    logic [AW-1:0] idx;
    logic [AW-1:0] next_idx;
    logic [AW-1:0] loB;
    logic [AW-1:0] hiB;
    logic dirDown;
    logic doneEv;
    logic errEv;

    // Address and data phase decode
    wire addrPhase = hsel && htrans[1] && hready;
    wire dataWr = dValid && dWrite;
    wire isIdle = (state == AWS_IDLE);
    wire wrCtrl = dataWr && (dAddr == `AWS_OFS_CTRL);
    wire trigger = wrCtrl && isIdle && hwdata[`AWS_CTRL_GO];
    wire execCond = hwdata[`AWS_CTRL_COND];
    // Operand writes are held off while an execution runs
    wire wrCfg = dataWr && isIdle;
    wire memHit = (dAddr[11:8] == `AWS_MEM_PAGE) &&
                  ({2'b00, dAddr[7:2]} < 8'(DEPTH));
    wire memBusWr = wrCfg && memHit && !trigger;
    wire [AW-1:0] dIndex = dAddr[AW+1:2];
    wire [AW-1:0] aIndex = haddr[AW+1:2];
    wire aMemHit = (haddr[11:8] == `AWS_MEM_PAGE) &&
                   ({2'b00, haddr[7:2]} < 8'(DEPTH));

    // Range resolution and checks
    aws_resolve_type startRes;
    aws_resolve_type endRes;
    // A process, not an assign, so later pointer word writes are seen too
    always_comb begin
        startRes = resolve(startOp);
        endRes = resolve(endOp);
    end
    wire rangeErr = (areaOf(startRes.addr) != areaOf(endRes.addr)) ||
                    (startRes.addr > endRes.addr);
    wire execErr = startRes.err || endRes.err || rangeErr;

    // Shift step: neighbour in the direction data moves from
    wire [AW-1:0] nbIdx = dirDown ? AW'(idx + 1'b1) : AW'(idx - 1'b1);
    wire atLast = dirDown ? (idx == hiB) : (idx == loB);
    wire nbIsBound = dirDown ? (nbIdx == hiB) : (nbIdx == loB);
    // zero word takes a non-zero neighbour
    wire doSwap = (state == AWS_SHIFT) && !atLast &&
                  (mem[idx] == `AWS_RST_WORD) &&
                  (mem[nbIdx] != `AWS_RST_WORD);

    // Read mux for the address phase
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (haddr[11:0])
            `AWS_OFS_CWORD: rdMux = {16'h0000, cword};
            `AWS_OFS_START: rdMux = {15'h0000, startOp};
            `AWS_OFS_END: rdMux = {15'h0000, endOp};
            `AWS_OFS_STATUS: begin
                rdMux[`AWS_ST_BUSY] = !isIdle;
                rdMux[`AWS_ST_ERR] = errorFlag;
            end
            `AWS_OFS_IRQSTAT: rdMux[`AWS_EV_W-1:0] = irqStat;
            `AWS_OFS_IRQMASK: rdMux[`AWS_EV_W-1:0] = irqMask;
            default: begin
                if (aMemHit) begin
                    rdMux = {16'h0000, mem[aIndex]};
                end
            end
        endcase
    end

    // Execution sequencer
    always_comb begin
        next_state = state;
        next_idx = idx;
        doneEv = 1'b0;
        errEv = 1'b0;
        unique case (state)
            AWS_IDLE: begin
                if (trigger) begin
                    if (!execCond) begin
                        doneEv = 1'b1;
                    end else if (execErr) begin
                        doneEv = 1'b1;
                        errEv = 1'b1;
                    end else if (cword.clear) begin
                        next_state = AWS_CLEAR;
                        next_idx = startRes.addr[AW-1:0];
                    end else if (cword.enable) begin
                        next_state = AWS_SHIFT;
                        next_idx = cword.down ? startRes.addr[AW-1:0]
                                              : endRes.addr[AW-1:0];
                    end else begin
                        doneEv = 1'b1;
                    end
                end
            end
            AWS_CLEAR: begin
                next_idx = AW'(idx + 1'b1);
                if (idx == hiB) begin
                    next_state = AWS_IDLE;
                    doneEv = 1'b1;
                end
            end
            AWS_SHIFT: begin
                if (atLast || (doSwap && nbIsBound)) begin
                    next_state = AWS_IDLE;
                    doneEv = 1'b1;
                end else if (doSwap) begin
                    next_idx = dirDown ? AW'(nbIdx + 1'b1)
                                       : AW'(nbIdx - 1'b1);
                end else begin
                    next_idx = nbIdx;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= AWS_IDLE;
            idx <= '0;
            loB <= '0;
            hiB <= '0;
            dirDown <= 1'b0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            if (trigger) begin
                loB <= startRes.addr[AW-1:0];
                hiB <= endRes.addr[AW-1:0];
                dirDown <= cword.down;
            end
        end
    end

    // Data memory: no reset, contents belong to the program
    always_ff @(posedge ref_clk) begin
        if (memBusWr) begin
            mem[dIndex] <= hwdata[15:0];
        end
        if (state == AWS_CLEAR) begin
            mem[idx] <= `AWS_RST_WORD;
        end
        if (doSwap) begin
            mem[idx] <= mem[nbIdx];
            mem[nbIdx] <= `AWS_RST_WORD;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dValid <= 1'b0;
            dWrite <= 1'b0;
            dAddr <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            dValid <= addrPhase;
            dWrite <= hwrite;
            dAddr <= haddr[11:0];
            hrdata <= rdMux;
            // Zero wait states: the read mux is sampled in the address phase
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cword <= `AWS_RST_WORD;
            startOp <= '0;
            endOp <= '0;
            irqMask <= `AWS_RST_EV;
        end else if (wrCfg) begin
            unique case (dAddr)
                `AWS_OFS_CWORD: cword <= hwdata[15:0];
                `AWS_OFS_START: startOp <= hwdata[16:0];
                `AWS_OFS_END: endOp <= hwdata[16:0];
                `AWS_OFS_IRQMASK: irqMask <= hwdata[`AWS_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // Event set wins over a same-cycle write-one-to-clear
    wire [`AWS_EV_W-1:0] evSet = {errEv, doneEv};
    wire [`AWS_EV_W-1:0] evClr =
        (dataWr && dAddr == `AWS_OFS_IRQSTAT) ? hwdata[`AWS_EV_W-1:0]
                                               : `AWS_RST_EV;
    wire [`AWS_EV_W-1:0] next_irqStat = (irqStat & ~evClr) | evSet;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqStat <= `AWS_RST_EV;
            irq <= 1'b0;
            errorFlag <= 1'b0;
        end else begin
            irqStat <= next_irqStat;
            irq <= |(next_irqStat & irqMask);
            if (trigger && execCond) begin
                errorFlag <= execErr;
            end
        end
    end

endmodule

// File: hw/aws_defs.svh
// Register offsets, bit positions and reset values of the word shifter
// Summary of operation
// - Condition false: touch nothing, just finish
// - Flag error on area mismatch or start above end
// - Move word only into zero neighbour
// - At most one move per zero word
// - Vacated word is written zero
// - Control bits 0 to 12 ignored
// - Bit 13 set moves data downward
// - Bit 14 clear: no shifting
// - Bit 15 clears whole range
// - Flag bad indirect pointers as errors
`ifndef AWS_DEFS_SVH
`define AWS_DEFS_SVH

// Word offsets on the bus (byte addresses, bits 11:0)
`define AWS_OFS_CTRL 12'h000
`define AWS_OFS_CWORD 12'h004
`define AWS_OFS_START 12'h008
`define AWS_OFS_END 12'h00c
`define AWS_OFS_STATUS 12'h010
`define AWS_OFS_IRQSTAT 12'h014
`define AWS_OFS_IRQMASK 12'h018
`define AWS_MEM_PAGE 4'h1

// Command register bits
`define AWS_CTRL_GO 0
`define AWS_CTRL_COND 1

// Status register bits
`define AWS_ST_BUSY 0
`define AWS_ST_ERR 1

// Event bits, shared by the sticky status and the mask
`define AWS_EV_DONE 0
`define AWS_EV_ERR 1
`define AWS_EV_W 2

// Reset values
`define AWS_RST_WORD 16'h0000
`define AWS_RST_EV 2'h0

`endif

// File: hw/aws_pkg.sv
// Types shared by the asynchronous word shift register
package aws_pkg;

    // Shift control word, packed in its bit order 15..0
    typedef struct packed {
        logic clear;
        logic enable;
        logic down;
        logic [12:0] unused;
    } aws_cword_type;

    // Range operand: direct address, or address of a BCD pointer word
    typedef struct packed {
        logic indirect;
        logic [15:0] addr;
    } aws_operand_type;

    // Result of resolving an operand
    typedef struct packed {
        logic err;
        logic [15:0] addr;
    } aws_resolve_type;

    typedef enum logic [1:0] {
        AWS_IDLE = 2'b00,
        AWS_CLEAR = 2'b01,
        AWS_SHIFT = 2'b10
    } aws_state_type;

endpackage

// File: testbench/aws_shift_register_properties.sv
// Bus and interrupt properties of the word shift register
module aws_shift_register_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus request
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Bus answer and interrupt
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic irq
);
    wire logic taken = hsel && htrans[1] && hready;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_rd(logic [11:0] a);
        taken && !hwrite && haddr[11:0] == a;
    endsequence
    sequence s_mask_off;
        taken && hwrite && haddr[11:0] == 12'h018 ##1 hwdata[1:0] == 2'h0;
    endsequence
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_ready;
        !$past(rst) |-> hreadyout;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_ctrl;
        s_rd(12'h000) |=> hrdata == 32'h0;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("command read not zero");
    property p_unmap;
        s_rd(12'h020) |=> hrdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_stat;
        s_rd(12'h010) |=> hrdata[31:2] == 30'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("status high bits set");
    property p_istat;
        s_rd(12'h014) |=> hrdata[31:2] == 30'h0;
    endproperty
    a_istat: assert property (p_istat) else $error("event high bits set");
    property p_mem;
        taken && !hwrite && haddr[11:8] == 4'h1 |=> hrdata[31:16] == 16'h0;
    endproperty
    a_mem: assert property (p_mem) else $error("memory high half set");
    property p_irq;
        s_mask_off |=> ##1 !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt while masked");
endmodule

// File: testbench/aws_seq_master.sv
// Sequencer model: bus master that loads operands and starts execution
module aws_seq_master (
    // Clock and bus answer
    input wire logic ref_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        // Stale data is inverted so it never passes for a fresh value
        hwdata <= ~hwdata;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic run(input logic [31:0] st, input logic [31:0] en,
            input logic [31:0] cw, input logic c, output logic [31:0] s);
        xfer(1'b1, 12'h008, st, s);
        xfer(1'b1, 12'h00c, en, s);
        xfer(1'b1, 12'h004, cw, s);
        xfer(1'b1, 12'h000, {30'h0, c, 1'b1}, s);
        s = 32'h1;
        for (int i = 0; i < 100 && s[0] !== 1'b0; i++)
            xfer(1'b0, 12'h010, 32'h0, s);
    endtask
endmodule

// File: testbench/test_aws_shift_register.sv
// Self-checking bench for the word shift register
module test_aws_shift_register;
    timeunit 1ns;
    timeprecision 1ns;
    logic refClk = 1'b0;
    logic rst = 1'b1;
    logic hsel, hwrite, hready, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [15:0] exp [64];
    int errCount = 0;
    int nTests = 0;
    aws_shift_register u_aws_shift_register (.ref_clk(refClk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .irq(irq));
    aws_seq_master u_aws_seq_master (.ref_clk(refClk), .hready(hready),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    initial begin
        forever #25 refClk = ~refClk;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        nTests++;
        if (g !== e) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        u_aws_seq_master.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(logic [11:0] a);
        u_aws_seq_master.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic put(int i, logic [15:0] v);
        exp[i] = v;
        wr(12'(12'h100 + i * 4), {16'h0, v});
    endtask
    task automatic chkMem;
        for (int i = 0; i < 64; i++) begin
            rd(12'(12'h100 + i * 4));
            chk("memory word", {16'h0, exp[i]}, q);
        end
    endtask
    task automatic go(logic [31:0] st, logic [31:0] en, logic [31:0] cw,
            logic c);
        u_aws_seq_master.run(st, en, cw, c, q);
        chk("busy", 32'h0, q & 32'h1);
    endtask
    task automatic tDown;
        logic [15:0] b [11] = '{16'h1234, 16'h0, 16'h0, 16'h2345, 16'h3456,
            16'h0, 16'h4567, 16'h5678, 16'h6789, 16'h0, 16'h789a};
        logic [15:0] a [11] = '{16'h1234, 16'h0, 16'h2345, 16'h0, 16'h3456,
            16'h4567, 16'h0, 16'h5678, 16'h6789, 16'h789a, 16'h0};
        for (int i = 0; i < 11; i++) put(10 + i, b[i]);
        go(32'h0a, 32'h14, 32'h7fff, 1'b1);
        for (int i = 0; i < 11; i++) exp[10 + i] = a[i];
        chkMem(); // one step down
        $display("downward shift test done");
    endtask
    task automatic tUpHold;
        put(40, 16'h0abc);
        put(41, 16'h0);
        put(42, 16'h0);
        go(32'h28, 32'h2a, 32'h4000, 1'b1);
        exp[40] = 16'h0;
        exp[41] = 16'h0abc;
        chkMem(); // one step up
        go(32'h28, 32'h2a, 32'h4000, 1'b0);
        chkMem(); // condition off
        go(32'h28, 32'h2a, 32'h2000, 1'b1);
        chkMem(); // shifting disabled
        go(32'h0, 32'h05, 32'h4000, 1'b1);
        chkMem(); // range without zero
        $display("upward and hold test done");
    endtask
    task automatic tClearErr;
        for (int i = 40; i < 43; i++) put(i, 16'h1111);
        go(32'h28, 32'h2a, 32'he000, 1'b1);
        for (int i = 40; i < 43; i++) exp[i] = 16'h0;
        chkMem(); // range cleared only
        go(32'h2f, 32'h2d, 32'hc000, 1'b1);
        chk("error flag", 32'h2, q & 32'h2); // start above end
        go(32'h1e, 32'h21, 32'hc000, 1'b1);
        chk("error flag", 32'h2, q & 32'h2); // two areas
        put(50, 16'h001a);
        go(32'h10032, 32'h34, 32'hc000, 1'b1);
        chk("error flag", 32'h2, q & 32'h2); // pointer not decimal
        chkMem(); // errors write nothing
        put(41, 16'h5555);
        put(60, 16'h0040);
        go(32'h1003c, 32'h2a, 32'h8000, 1'b1);
        chk("error flag", 32'h0, q & 32'h2); // decimal pointer taken
        for (int i = 40; i < 43; i++) exp[i] = 16'h0;
        chkMem(); // range through pointer cleared
        $display("clear and error test done");
    endtask
    task automatic tIrq;
        wr(12'h014, 32'h3);
        wr(12'h018, 32'h1);
        go(32'h0, 32'h1, 32'h0, 1'b0);
        chk("irq", 32'h1, {31'h0, irq});
        wr(12'h014, 32'h1);
        repeat (2) @(posedge refClk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(12'h018, 32'h2);
        go(32'h1, 32'h0, 32'h0, 1'b1);
        chk("irq", 32'h1, {31'h0, irq}); // error event
        rd(12'h014);
        chk("event bits", 32'h3, q);
        wr(12'h018, 32'h0);
        repeat (2) @(posedge refClk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(12'h020);
        chk("unmapped", 32'h0, q);
        rd(12'h000);
        chk("command", 32'h0, q);
        $display("interrupt test done");
    endtask
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge refClk);
        rst <= 1'b0;
        @(posedge refClk);
        for (int i = 0; i < 64; i++) put(i, 16'(16'h0100 + i));
        tDown();
        tUpHold();
        tClearErr();
        tIrq();
        wrapUp();
    end
    initial begin
        #1000000;
        errCount++;
        wrapUp();
    end
endmodule
bind aws_shift_register aws_shift_register_properties
    u_aws_shift_register_properties (.ref_clk(ref_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));
